// >>> rtl/mdsr_status_bank.sv
// Read-only status register bank of the motor driver with its open-drain error pin.
`timescale 1ns/1ns
`default_nettype none
module mdsr_status_bank (
   input  wire logic                                clk,
   input  wire logic                                sys_rst,
   input  wire mdsr_pkg::mdsr_errors_t              errorEvent,
   input  wire logic                                clearErrorsCmd,
   input  wire logic                                supplyAboveThreshold,
   input  wire logic [7:0]                          rippleSpeed,
   input  wire logic [mdsr_pkg::RAW_VOLTAGE_W-1:0]  terminalVoltageRaw,
   input  wire logic [7:0]                          windingCurrentCode,
   input  wire logic [mdsr_pkg::DUTY_W-1:0]         dutyRead,
   input  wire mdsr_pkg::mdsr_rd_req_t              rdReq,
   input  wire mdsr_pkg::mdsr_wr_req_t              wrReq,
   output logic [mdsr_pkg::DATA_W-1:0]              rdData,
   output logic                                     rdValid,
   output logic                                     wrIgnored,
   output logic                                     errorOutLowPinOut,
   output logic                                     errorOutLowPinOe,
   output logic                                     summaryError
);

   // Error latches.
   mdsr_pkg::mdsr_errors_t errorFlag;
   logic                   powerOnSeenFlag;
   logic                   next_summary;

   mdsr_error_latch u_error_latch (
      .clk                  (clk),
      .sys_rst              (sys_rst),
      .errorEvent           (errorEvent),
      .clearErrorsCmd       (clearErrorsCmd),
      .supplyAboveThreshold (supplyAboveThreshold),
      .next_summary         (next_summary),
      .errorFlag            (errorFlag),
      .powerOnSeenFlag      (powerOnSeenFlag)
   );

   // Readout holding registers.
   logic [7:0]                  rippleSpeedReg;
   logic [7:0]                  terminalVoltageReg;
   logic [7:0]                  windingCurrentReg;
   logic [mdsr_pkg::DUTY_W-1:0] dutyReg;
   logic [7:0]                  next_rippleSpeed;
   logic [7:0]                  next_terminalVoltage;
   logic [7:0]                  next_windingCurrent;
   logic [mdsr_pkg::DUTY_W-1:0] next_duty;

   // The raw measurement is one bit wider than the code so that large terminal
   // voltages clip at the top code instead of wrapping to a small one.
   always_comb begin
      next_rippleSpeed    = rippleSpeed;
      next_windingCurrent = windingCurrentCode;
      next_duty           = dutyRead;
      if (terminalVoltageRaw[mdsr_pkg::RAW_VOLTAGE_W-1]) begin
         next_terminalVoltage = mdsr_pkg::CODE_MAX;
      end else begin
         next_terminalVoltage = terminalVoltageRaw[7:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rippleSpeedReg     <= mdsr_pkg::REG_RESET;
         terminalVoltageReg <= mdsr_pkg::REG_RESET;
         windingCurrentReg  <= mdsr_pkg::REG_RESET;
         dutyReg            <= '0;
      end else begin
         rippleSpeedReg     <= next_rippleSpeed;
         terminalVoltageReg <= next_terminalVoltage;
         windingCurrentReg  <= next_windingCurrent;
         dutyReg            <= next_duty;
      end
   end

   // Error flags byte as software sees it.
   logic [7:0] errorFlagsByte;

   always_comb begin
      errorFlagsByte                            = 8'h00;
      errorFlagsByte[mdsr_pkg::SUMMARY_BIT]     = summaryError;
      errorFlagsByte[mdsr_pkg::STALL_BIT]       = errorFlag.stall;
      errorFlagsByte[mdsr_pkg::OVERCURRENT_BIT] = errorFlag.overcurrent;
      errorFlagsByte[mdsr_pkg::OVERVOLTAGE_BIT] = errorFlag.overvoltage;
      errorFlagsByte[mdsr_pkg::OVERTEMP_BIT]    = errorFlag.overtemp;
      errorFlagsByte[mdsr_pkg::POWER_ON_BIT]    = powerOnSeenFlag;
   end

   // Read port: the byte is sampled on the strobe edge, which the serial engine
   // raises when it starts shifting the data byte out.
   logic [7:0] next_rdData;
   logic       next_rdValid;
   logic       next_wrIgnored;

   always_comb begin
      next_rdValid   = rdReq.strobe;
      next_rdData    = rdData;
      next_wrIgnored = wrReq.strobe;
      if (rdReq.strobe) begin
         case (rdReq.addr)
            mdsr_pkg::ERROR_FLAGS_OFS: begin
               next_rdData = errorFlagsByte;
            end
            mdsr_pkg::RIPPLE_SPEED_OFS: begin
               next_rdData = rippleSpeedReg;
            end
            mdsr_pkg::TERMINAL_VOLTAGE_OFS: begin
               next_rdData = terminalVoltageReg;
            end
            mdsr_pkg::WINDING_CURRENT_OFS: begin
               next_rdData = windingCurrentReg;
            end
            mdsr_pkg::REGULATION_STATUS_C_OFS: begin
               next_rdData = {2'h0, dutyReg};
            end
            default: begin
               // Reserved offsets and anything outside the bank read as zero.
               next_rdData = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdData    <= mdsr_pkg::REG_RESET;
         rdValid   <= 1'b0;
         wrIgnored <= 1'b0;
      end else begin
         rdData    <= next_rdData;
         rdValid   <= next_rdValid;
         wrIgnored <= next_wrIgnored;
      end
   end

   // Summary flag and open-drain pin share one next value, so the pin and bit 7
   // always agree on the same edge.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         summaryError      <= 1'b0;
         errorOutLowPinOe  <= 1'b0;
         errorOutLowPinOut <= 1'b0;
      end else begin
         summaryError      <= next_summary;
         errorOutLowPinOe  <= next_summary;
         errorOutLowPinOut <= 1'b0;
      end
   end

endmodule // mdsr_status_bank
`default_nettype wire

// >>> rtl/mdsr_pkg.sv
// Package of offsets, field positions, reset values and carriers for the status bank.
package mdsr_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register offsets of the status bank.
   localparam logic [7:0] ERROR_FLAGS_OFS         = 8'h00;
   localparam logic [7:0] RIPPLE_SPEED_OFS        = 8'h01;
   localparam logic [7:0] SPEED_RSVD_A_OFS        = 8'h02;
   localparam logic [7:0] SPEED_RSVD_B_OFS        = 8'h03;
   localparam logic [7:0] TERMINAL_VOLTAGE_OFS    = 8'h04;
   localparam logic [7:0] WINDING_CURRENT_OFS     = 8'h05;
   localparam logic [7:0] REGULATION_STATUS_C_OFS = 8'h06;
   localparam logic [7:0] REGULATION_STATUS_D_OFS = 8'h07;
   localparam logic [7:0] REGULATION_STATUS_E_OFS = 8'h08;

   // Bit positions inside error_flags.
   localparam int unsigned SUMMARY_BIT     = 7;
   localparam int unsigned STALL_BIT       = 5;
   localparam int unsigned OVERCURRENT_BIT = 4;
   localparam int unsigned OVERVOLTAGE_BIT = 3;
   localparam int unsigned OVERTEMP_BIT    = 2;
   localparam int unsigned POWER_ON_BIT    = 1;

   localparam int unsigned DUTY_W          = 6;
   localparam int unsigned RAW_VOLTAGE_W   = 9;
   localparam int unsigned NUM_ERR         = 4;

   // Voltage code scale: 0x00 is 0 V, 0xB0 is 11 V, saturating at 0xFF.
   localparam logic [7:0] VOLTAGE_11V_CODE = 8'hB0;
   localparam logic [7:0] CODE_MAX         = 8'hFF;
   // Current code full scale set by the sense gain.
   localparam logic [7:0] CURRENT_FS_CODE  = 8'hC0;

   localparam logic [7:0] REG_RESET        = 8'h00;

   // Latched protection flags, one bit per detector; index order fixed below.
   typedef struct packed {
      logic stall;
      logic overcurrent;
      logic overvoltage;
      logic overtemp;
   } mdsr_errors_t;

   // Register read request from the serial engine: strobe at the byte shift-out moment.
   typedef struct packed {
      logic              strobe;
      logic [ADDR_W-1:0] addr;
   } mdsr_rd_req_t;

   // Register write request from the serial engine; the status bank ignores the data.
   typedef struct packed {
      logic              strobe;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } mdsr_wr_req_t;

endpackage

// >>> rtl/mdsr_error_latch.sv
// Sticky protection flags and power-on indicator of the status bank.
`timescale 1ns/1ns
`default_nettype none
module mdsr_error_latch (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire mdsr_pkg::mdsr_errors_t errorEvent,
   input  wire logic                  clearErrorsCmd,
   input  wire logic                  supplyAboveThreshold,
   output logic                       next_summary,
   output mdsr_pkg::mdsr_errors_t     errorFlag,
   output logic                       powerOnSeenFlag
);

   logic [mdsr_pkg::NUM_ERR-1:0] evBits;
   logic [mdsr_pkg::NUM_ERR-1:0] flagBits;
   logic [mdsr_pkg::NUM_ERR-1:0] next_flagBits;
   logic                         supplyPrev;
   logic                         next_powerOnSeen;

   assign evBits    = errorEvent;
   assign errorFlag = flagBits;

   // A detector event in the clearing cycle survives the clear.
   genvar gi;
   generate
      for (gi = 0; gi < mdsr_pkg::NUM_ERR; gi++) begin : g_flag
         always_comb begin
            next_flagBits[gi] = evBits[gi] | (flagBits[gi] & ~clearErrorsCmd);
         end
      end
   endgenerate

   // Summary follows the flags that will be held after this edge.
   always_comb begin
      next_summary = |next_flagBits;
   end

   // Supply rising above threshold forces the indicator low and outranks a clear.
   always_comb begin
      next_powerOnSeen = powerOnSeenFlag;
      if (supplyAboveThreshold && !supplyPrev) begin
         next_powerOnSeen = 1'b0;
      end else if (clearErrorsCmd) begin
         next_powerOnSeen = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flagBits        <= '0;
         supplyPrev      <= 1'b0;
         powerOnSeenFlag <= 1'b0;
      end else begin
         flagBits        <= next_flagBits;
         supplyPrev      <= supplyAboveThreshold;
         powerOnSeenFlag <= next_powerOnSeen;
      end
   end

endmodule // mdsr_error_latch
`default_nettype wire

// >>> sim/mdsr_status_monitor.sv
// Port checker of the status bank.
`timescale 1ns/1ns
`default_nettype none
module mdsr_status_monitor (
   input wire logic                   clk,
   input wire logic                   sys_rst,
   input wire mdsr_pkg::mdsr_errors_t errorEvent,
   input wire logic                   clearErrorsCmd,
   input wire mdsr_pkg::mdsr_rd_req_t rdReq,
   input wire mdsr_pkg::mdsr_wr_req_t wrReq,
   input wire logic [7:0]             rdData,
   input wire logic                   rdValid,
   input wire logic                   wrIgnored,
   input wire logic                   errorOutLowPinOut,
   input wire logic                   errorOutLowPinOe,
   input wire logic                   summaryError
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence clearNoEvent;
      clearErrorsCmd && errorEvent == '0;
   endsequence
   sequence readOf(logic [7:0] a);
      rdReq.strobe && rdReq.addr == a;
   endsequence
   a_read_answer: assert property (rdReq.strobe |=> rdValid)
      else $error("read not answered");
   a_valid_cause: assert property (rdValid |-> $past(rdReq.strobe))
      else $error("valid without request");
   a_write_ignored: assert property (wrReq.strobe |=> wrIgnored)
      else $error("write not acknowledged");
   a_pin_follows: assert property (errorOutLowPinOe == summaryError && !errorOutLowPinOut)
      else $error("error pin wrong");
   a_event_sets: assert property (errorEvent != '0 |=> summaryError)
      else $error("summary not set");
   a_clear_drops: assert property (clearNoEvent |=> !summaryError)
      else $error("summary not cleared");
   a_summary_holds: assert property (summaryError && !clearErrorsCmd |=> summaryError)
      else $error("summary lost");
   a_reserved_zero: assert property (readOf(8'h02) or readOf(8'h03) |=> rdData == 8'h00)
      else $error("reserved read nonzero");
   a_fault_byte: assert property (readOf(8'h00) |=>
      rdData[7] == $past(summaryError) && !rdData[6] && !rdData[0])
      else $error("error byte wrong");
endmodule // mdsr_status_monitor
bind mdsr_status_bank mdsr_status_monitor mon (.clk, .sys_rst, .errorEvent, .clearErrorsCmd,
   .rdReq, .wrReq, .rdData, .rdValid, .wrIgnored, .errorOutLowPinOut, .errorOutLowPinOe,
   .summaryError);
`default_nettype wire

// >>> sim/mdsr_host_model.sv
// Stand-in for the serial bus leader that issues register requests.
`timescale 1ns/1ns
`default_nettype none
module mdsr_host_model (
   input  wire logic                  clk,
   input  wire logic                  rdValid,
   input  wire logic [7:0]            rdData,
   output var mdsr_pkg::mdsr_rd_req_t rdReq,
   output var mdsr_pkg::mdsr_wr_req_t wrReq
);
   initial begin
      rdReq = '0;
      wrReq = '0;
   end
   // Idle address is inverted so a stale request never looks valid.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 'x;
      @(negedge clk);
      rdReq = {1'b1, a};
      @(negedge clk);
      rdReq = {1'b0, ~a};
      // The answer pulse stands only between the two edges after the strobe,
      // so it is looked at before any further edge is let pass.
      repeat (4) begin
         if (rdValid === 1'b1) begin
            d = rdData;
            break;
         end
         @(negedge clk);
      end
   endtask
   // Only listed offsets are ever written.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      wrReq = {1'b1, a, v};
      @(negedge clk);
      wrReq = {1'b0, ~a, ~v};
   endtask
endmodule // mdsr_host_model
`default_nettype wire

// >>> sim/motor_driver_status_regs_bench.sv
// Self-checking bench of the motor driver status bank.
`timescale 1ns/1ns
`default_nettype none
module motor_driver_status_regs_bench;
   logic clk, sys_rst, clearErrorsCmd, supplyAboveThreshold;
   logic rdValid, wrIgnored, pinOut, pinOe, summaryError;
   logic [7:0] rippleSpeed, windingCurrentCode, rdData, got;
   logic [8:0] terminalVoltageRaw;
   logic [5:0] dutyRead;
   mdsr_pkg::mdsr_errors_t errorEvent;
   mdsr_pkg::mdsr_rd_req_t rdReq;
   mdsr_pkg::mdsr_wr_req_t wrReq;
   wire errorPin = pinOe ? pinOut : 1'b1;
   int err_total = 0;
   int samples_checked = 0;
   logic [15:0] rows [10] = '{16'h015A, 16'h0200, 16'h0300, 16'h04B0, 16'h05C0,
                              16'h063F, 16'h0700, 16'h0800, 16'h0900, 16'hFF00};
   mdsr_status_bank dut (.clk, .sys_rst, .errorEvent, .clearErrorsCmd, .supplyAboveThreshold,
      .rippleSpeed, .terminalVoltageRaw, .windingCurrentCode, .dutyRead, .rdReq, .wrReq,
      .rdData, .rdValid, .wrIgnored, .errorOutLowPinOut(pinOut), .errorOutLowPinOe(pinOe),
      .summaryError);
   mdsr_host_model host (.clk, .rdValid, .rdData, .rdReq, .wrReq);
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, got);
      chk(got, e);
   endtask
   task automatic pulse_clear;
      @(negedge clk);
      clearErrorsCmd = 1'b1;
      @(negedge clk);
      clearErrorsCmd = 1'b0;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #100000;
      err_total++;
      complete_run;
   end
   initial begin
      sys_rst = 1'b1;
      errorEvent = '0;
      clearErrorsCmd = 1'b0;
      supplyAboveThreshold = 1'b1;
      rippleSpeed = 8'h5A;
      terminalVoltageRaw = 9'h0B0;
      windingCurrentCode = 8'hC0;
      dutyRead = 6'h3F;
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      rd(8'h00, 8'h00);
      chk({7'h00, errorPin}, 8'h01);
      foreach (rows[i]) rd(rows[i][15:8], rows[i][7:0]);
      $display("test readouts done");
      pulse_clear;
      rd(8'h00, 8'h02);
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         errorEvent = mdsr_pkg::mdsr_errors_t'(4'h1 << i);
         @(negedge clk);
         errorEvent = '0;
         rd(8'h00, 8'h82 | (8'h04 << i));
         chk({7'h00, errorPin}, 8'h00);
         host.wr(8'h00, 8'h00);
         rd(8'h00, 8'h82 | (8'h04 << i));
         pulse_clear;
         rd(8'h00, 8'h02);
         chk({7'h00, errorPin}, 8'h01);
      end
      $display("test flags done");
      terminalVoltageRaw = 9'h1C3;
      rd(8'h04, 8'hFF);
      @(negedge clk);
      supplyAboveThreshold = 1'b0;
      @(negedge clk);
      supplyAboveThreshold = 1'b1;
      rd(8'h00, 8'h00);
      // A supply rise in the same cycle as a clear must still win.
      pulse_clear;
      @(negedge clk);
      supplyAboveThreshold = 1'b0;
      @(negedge clk);
      supplyAboveThreshold = 1'b1;
      clearErrorsCmd = 1'b1;
      @(negedge clk);
      clearErrorsCmd = 1'b0;
      rd(8'h00, 8'h00);
      $display("test supply done");
      // A second reset in mid-run must drop a latched flag too.
      @(negedge clk);
      errorEvent = 4'h8;
      @(negedge clk);
      errorEvent = '0;
      chk({7'h00, summaryError}, 8'h01);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      rd(8'h00, 8'h00);
      $display("test reset done");
      complete_run;
   end
endmodule // motor_driver_status_regs_bench
`default_nettype wire
